//--- rtl/prsw_defines.svh
`ifndef PRSW_DEFINES_SVH
`define PRSW_DEFINES_SVH

// Readback word layout
`define PRSW_WORD_WIDTH      24
`define PRSW_TYPE_HI_POS     23
`define PRSW_TYPE_LO_POS     22
`define PRSW_CHAN_ON_POS     21
`define PRSW_FORCE_SW_POS    11
`define PRSW_SENSE_SW_POS    10
`define PRSW_CLAMP_POS       9
`define PRSW_CMP_OUT_POS     8
`define PRSW_COMPARE_V_POS   7
`define PRSW_ALARM_LATCH_POS 6
`define PRSW_ALARM_LIVE_POS  5
`define PRSW_CMP_FIELD_MSB   21

// Word type codes carried in bits 23:22
`define PRSW_PMU_TYPE        2'h0
`define PRSW_CMP_TYPE        2'h1

// Reset values of the per-channel state
`define PRSW_RST_CHAN_ON     1'b0
`define PRSW_RST_FORCE_SW    1'b0
`define PRSW_RST_SENSE_SW    1'b0
`define PRSW_RST_CLAMP       1'b0
`define PRSW_RST_CMP_OUT     1'b0
`define PRSW_RST_COMPARE_V   1'b0

// Shift frame length in serial clock edges
`define PRSW_SHIFT_COUNT     5'h18

`endif

//--- rtl/prsw_pkg.sv
package prsw_pkg;

    // Which readback word the host asked for
    typedef enum logic {
        PRSW_PMU_WORD,
        PRSW_CMP_WORD
    } prsw_word_type;

    // Serial readback frame states
    typedef enum logic {
        PRSW_IDLE,
        PRSW_SHIFT
    } prsw_fsm_type;

endpackage

//--- rtl/prsw_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser: a bit changes once stages two and three agree
module prsw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_syncOut;

    // Accept each bit only when the two settled stages match
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_syncOut[i] = (stage2[i] == stage3[i]) ? stage3[i]
                                                       : syncOut[i];
        end
    end

    // Register chain
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            stage2  <= stage1;
            stage3  <= stage2;
            syncOut <= next_syncOut;
        end
    end

endmodule

`default_nettype wire

//--- rtl/prsw_readback.sv
`timescale 1ns/1ps
`default_nettype none
`include "prsw_defines.svh"

// Notes on behaviour
// - PMU word bit 9 shows clamp enable
// - Clamp bit follows last write, either path
// - PMU word bit 8 shows comparator output enable
// - Comparator enable follows last write, either path
// - Bit 7 high means comparing voltage
// - Bit 6 latched, bit 5 live temperature alarm
// - Alarm flags follow the alarm output pin
// - Latched alarm holds until clear bit written while the alarm pin is not driven
// - Unused readback positions return zeros
// - Comparator word read-only, type code 01
// - Bits 21..14 carry low/high comparator per channel
// - PMU word bit 21 shows channel enable
// - Bits 11 and 10 show system force and sense switched in
module prsw_readback #(
    parameter int NUM_CHAN = 4
) (
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire logic                    sysCtrlWrite,
    input  wire logic                    sysClampEn,
    input  wire logic                    sysCmpOutEn,
    input  wire logic                    pmuWrite,
    input  wire logic [NUM_CHAN-1:0]     pmuChanMask,
    input  wire logic                    pmuChannelOn,
    input  wire logic                    pmuForceSwitch,
    input  wire logic                    pmuSenseSwitch,
    input  wire logic                    pmuClampEn,
    input  wire logic                    pmuCmpOutEn,
    input  wire logic                    pmuCompareVolt,
    input  wire logic                    pmuClearAlarm,
    input  wire logic                    readbackReq,
    input  wire prsw_pkg::prsw_word_type readbackKind,
    input  wire logic [1:0]              readbackChan,
    input  wire logic                    overTempRaw,
    input  wire logic [NUM_CHAN-1:0]     cmpLowRaw,
    input  wire logic [NUM_CHAN-1:0]     cmpHighRaw,
    input  wire logic                    serialClkPin,
    input  wire logic                    serialSyncNPin,
    output var  logic                    serialOutLine,
    output var  logic                    serialOutOe,
    output var  logic                    thermAlarmPinOut,
    output var  logic                    thermAlarmPinOe,
    output var  logic                    readbackPending
);

    localparam int WW = `PRSW_WORD_WIDTH;

    // Synchronised pin levels
    logic                thermLive;
    logic [NUM_CHAN-1:0] cmpLow;
    logic [NUM_CHAN-1:0] cmpHigh;
    logic                sclkSync;
    logic                syncNSync;

    // Per-channel control state
    logic [NUM_CHAN-1:0] chanOn;
    logic [NUM_CHAN-1:0] forceSw;
    logic [NUM_CHAN-1:0] senseSw;
    logic [NUM_CHAN-1:0] clampEn;
    logic [NUM_CHAN-1:0] cmpOutEn;
    logic [NUM_CHAN-1:0] compareV;
    logic [NUM_CHAN-1:0] next_chanOn;
    logic [NUM_CHAN-1:0] next_forceSw;
    logic [NUM_CHAN-1:0] next_senseSw;
    logic [NUM_CHAN-1:0] next_clampEn;
    logic [NUM_CHAN-1:0] next_cmpOutEn;
    logic [NUM_CHAN-1:0] next_compareV;

    // Temperature alarm state
    logic thermLatched;
    logic next_thermLatched;
    logic next_thermAlarmPinOe;

    // Readback frame state
    prsw_pkg::prsw_fsm_type state;
    prsw_pkg::prsw_fsm_type next_state;
    logic [WW-1:0] heldWord;
    logic [WW-1:0] next_heldWord;
    logic [WW-1:0] shiftReg;
    logic [WW-1:0] next_shiftReg;
    logic [4:0]    bitCount;
    logic [4:0]    next_bitCount;
    logic          sclkPrev;
    logic          syncNPrev;
    logic          next_readbackPending;
    logic          next_serialOutLine;
    logic          next_serialOutOe;
    logic          sclkRise;
    logic          frameStart;
    logic          frameEnd;

    // Pins that arrive from outside the clock domain
    prsw_sync #(
        .WIDTH (3 + 2 * NUM_CHAN)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .asyncIn ({overTempRaw, cmpLowRaw, cmpHighRaw,
                   serialClkPin, serialSyncNPin}),
        .syncOut ({thermLive, cmpLow, cmpHigh, sclkSync, syncNSync})
    );

    // PMU state readback word for one channel; the live alarm bit uses
    // the registered pin drive so it always matches the pin
    function automatic logic [WW-1:0] pmuWord(input logic [1:0] ch);
        logic [WW-1:0] w;
        w = '0;
        w[`PRSW_TYPE_HI_POS:`PRSW_TYPE_LO_POS] = `PRSW_PMU_TYPE;
        w[`PRSW_CHAN_ON_POS]     = chanOn[ch];
        w[`PRSW_FORCE_SW_POS]    = forceSw[ch];
        w[`PRSW_SENSE_SW_POS]    = senseSw[ch];
        w[`PRSW_CLAMP_POS]       = clampEn[ch];
        w[`PRSW_CMP_OUT_POS]     = cmpOutEn[ch];
        w[`PRSW_COMPARE_V_POS]   = compareV[ch];
        w[`PRSW_ALARM_LATCH_POS] = thermLatched;
        w[`PRSW_ALARM_LIVE_POS]  = thermAlarmPinOe;
        return w;
    endfunction

    // Comparator status word, channel 0 first, low then high
    function automatic logic [WW-1:0] cmpWord();
        logic [WW-1:0] w;
        w = '0;
        w[`PRSW_TYPE_HI_POS:`PRSW_TYPE_LO_POS] = `PRSW_CMP_TYPE;
        for (int i = 0; i < NUM_CHAN; i++) begin
            w[`PRSW_CMP_FIELD_MSB - 2 * i]     = cmpLow[i];
            w[`PRSW_CMP_FIELD_MSB - 2 * i - 1] = cmpHigh[i];
        end
        return w;
    endfunction

    // Channel control: the later of the two write paths wins; when both
    // arrive in one cycle the PMU write is applied last and takes effect
    always_comb begin
        next_chanOn   = chanOn;
        next_forceSw  = forceSw;
        next_senseSw  = senseSw;
        next_clampEn  = clampEn;
        next_cmpOutEn = cmpOutEn;
        next_compareV = compareV;
        if (sysCtrlWrite) begin
            next_clampEn  = {NUM_CHAN{sysClampEn}};
            next_cmpOutEn = {NUM_CHAN{sysCmpOutEn}};
        end
        if (pmuWrite) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (pmuChanMask[i]) begin
                    next_chanOn[i]   = pmuChannelOn;
                    next_forceSw[i]  = pmuForceSwitch;
                    next_senseSw[i]  = pmuSenseSwitch;
                    next_clampEn[i]  = pmuClampEn;
                    next_cmpOutEn[i] = pmuCmpOutEn;
                    next_compareV[i] = pmuCompareVolt;
                end
            end
        end
    end

    // Channel control registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chanOn   <= {NUM_CHAN{`PRSW_RST_CHAN_ON}};
            forceSw  <= {NUM_CHAN{`PRSW_RST_FORCE_SW}};
            senseSw  <= {NUM_CHAN{`PRSW_RST_SENSE_SW}};
            clampEn  <= {NUM_CHAN{`PRSW_RST_CLAMP}};
            cmpOutEn <= {NUM_CHAN{`PRSW_RST_CMP_OUT}};
            compareV <= {NUM_CHAN{`PRSW_RST_COMPARE_V}};
        end else begin
            chanOn   <= next_chanOn;
            forceSw  <= next_forceSw;
            senseSw  <= next_senseSw;
            clampEn  <= next_clampEn;
            cmpOutEn <= next_cmpOutEn;
            compareV <= next_compareV;
        end
    end

    // Temperature alarm: pin follows the live level, latch holds
    // The set is applied after the clear, so an alarm that is still
    // live wins over a clear written in the same cycle
    always_comb begin
        next_thermAlarmPinOe = thermLive;
        next_thermLatched    = thermLatched;
        if (pmuWrite && pmuClearAlarm) begin
            next_thermLatched = 1'b0;
        end
        if (thermAlarmPinOe) begin
            next_thermLatched = 1'b1;
        end
    end

    // Alarm registers; the open-drain pin only ever pulls low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            thermLatched     <= 1'b0;
            thermAlarmPinOe  <= 1'b0;
            thermAlarmPinOut <= 1'b0;
        end else begin
            thermLatched     <= next_thermLatched;
            thermAlarmPinOe  <= next_thermAlarmPinOe;
            thermAlarmPinOut <= 1'b0;
        end
    end

    // Edge detection on the settled serial pins
    // Each serial clock half period must last two ref_clk cycles or more,
    // otherwise an edge is lost
    assign sclkRise   = sclkSync && !sclkPrev;
    assign frameStart = !syncNSync && syncNPrev;
    assign frameEnd   = syncNSync && !syncNPrev;

    // Readback request capture and serial shift frame
    always_comb begin
        next_state           = state;
        next_heldWord        = heldWord;
        next_readbackPending = readbackPending;
        next_shiftReg        = shiftReg;
        next_bitCount        = bitCount;
        next_serialOutOe     = serialOutOe;
        next_serialOutLine   = serialOutLine;
        case (state)
            prsw_pkg::PRSW_IDLE: begin
                if (frameStart) begin
                    next_state       = prsw_pkg::PRSW_SHIFT;
                    next_serialOutOe = 1'b1;
                    next_bitCount    = 5'h0;
                    if (readbackPending) begin
                        next_shiftReg        = heldWord;
                        next_serialOutLine   = heldWord[WW-1];
                        next_readbackPending = 1'b0;
                    end else begin
                        next_shiftReg      = '0;
                        next_serialOutLine = 1'b0;
                    end
                end
            end
            prsw_pkg::PRSW_SHIFT: begin
                if (frameEnd) begin
                    next_state         = prsw_pkg::PRSW_IDLE;
                    next_serialOutOe   = 1'b0;
                    next_serialOutLine = 1'b0;
                    // After the last data bit a further rise moves a zero
                    // onto the line; the count stops any rise beyond that
                end else if (sclkRise &&
                             bitCount != `PRSW_SHIFT_COUNT) begin
                    next_shiftReg      = {shiftReg[WW-2:0], 1'b0};
                    next_serialOutLine = shiftReg[WW-2];
                    next_bitCount      = bitCount + 5'h1;
                end
            end
            default: begin
                next_state       = prsw_pkg::PRSW_IDLE;
                next_serialOutOe = 1'b0;
            end
        endcase
        // One word per request; a later request replaces the earlier
        if (readbackReq) begin
            next_readbackPending = 1'b1;
            if (readbackKind == prsw_pkg::PRSW_CMP_WORD) begin
                next_heldWord = cmpWord();
            end else begin
                next_heldWord = pmuWord(readbackChan);
            end
        end
    end

    // Frame registers; the previous sync level resets to what the
    // synchroniser shows in reset, so no false frame start follows reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state           <= prsw_pkg::PRSW_IDLE;
            heldWord        <= '0;
            readbackPending <= 1'b0;
            shiftReg        <= '0;
            bitCount        <= 5'h0;
            serialOutOe     <= 1'b0;
            serialOutLine   <= 1'b0;
            sclkPrev        <= 1'b0;
            syncNPrev       <= 1'b0;
        end else begin
            state           <= next_state;
            heldWord        <= next_heldWord;
            readbackPending <= next_readbackPending;
            shiftReg        <= next_shiftReg;
            bitCount        <= next_bitCount;
            serialOutOe     <= next_serialOutOe;
            serialOutLine   <= next_serialOutLine;
            sclkPrev        <= sclkSync;
            syncNPrev       <= syncNSync;
        end
    end

endmodule

`default_nettype wire

//--- dv/prsw_readback_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the readback block
module prsw_checker (
    input wire logic                    ref_clk,
    input wire logic                    nrst,
    input wire logic                    readbackReq,
    input wire prsw_pkg::prsw_word_type readbackKind,
    input wire logic                    overTempRaw,
    input wire logic                    serialSyncNPin,
    input wire logic                    serialOutLine,
    input wire logic                    serialOutOe,
    input wire logic                    thermAlarmPinOut,
    input wire logic                    thermAlarmPinOe,
    input wire logic                    readbackPending
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Serial framing
    idle_line_low_a: assert property (
        !serialOutOe |-> !serialOutLine)
        else $error("serial line high outside frame");
    frame_on_sync_a: assert property (
        (!serialSyncNPin)[*8] |=> serialOutOe)
        else $error("no frame while sync held low");
    frame_off_sync_a: assert property (
        serialSyncNPin[*8] |=> !serialOutOe)
        else $error("frame active while sync high");
    // Pending word handling
    pend_after_req_a: assert property (
        readbackReq |=> readbackPending)
        else $error("request not held as pending");
    pend_until_frame_a: assert property (
        $fell(readbackPending) |-> $rose(serialOutOe))
        else $error("pending word dropped without frame");
    pend_hold_a: assert property (
        readbackPending && serialSyncNPin |=> readbackPending)
        else $error("pending word lost before frame");
    // Temperature alarm pin
    alarm_live_on_a: assert property (
        overTempRaw[*6] |=> thermAlarmPinOe)
        else $error("alarm pin not driven on over temperature");
    alarm_live_off_a: assert property (
        (!overTempRaw)[*6] |=> !thermAlarmPinOe)
        else $error("alarm pin driven without over temperature");
    alarm_pin_od_a: assert property (
        !thermAlarmPinOut)
        else $error("alarm pin drives high");
    // Main scenarios reached
    cmp_req_c: cover property (
        readbackReq && readbackKind == prsw_pkg::PRSW_CMP_WORD);
    frame_c: cover property ($rose(serialOutOe));
    alarm_c: cover property ($rose(thermAlarmPinOe));
endmodule

bind prsw_readback prsw_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .readbackReq(readbackReq), .readbackKind(readbackKind),
    .overTempRaw(overTempRaw), .serialSyncNPin(serialSyncNPin),
    .serialOutLine(serialOutLine), .serialOutOe(serialOutOe),
    .thermAlarmPinOut(thermAlarmPinOut), .thermAlarmPinOe(thermAlarmPinOe),
    .readbackPending(readbackPending));
`default_nettype wire

//--- dv/prsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial readback; serial clock idles high
module prsw_host_model (
    input  wire logic ref_clk,
    input  wire logic serialOutLine,
    output var  logic serialClkPin,
    output var  logic serialSyncNPin
);
    initial begin
        serialClkPin = 1'b1;
        serialSyncNPin = 1'b1;
    end
    // One frame reads one requested word, sampled on falling edges
    task automatic frame(input int half, output logic [23:0] w);
        serialSyncNPin <= 1'b0;
        repeat (half) @(posedge ref_clk);
        for (int i = 0; i < 24; i++) begin
            serialClkPin <= 1'b0;
            w = {w[22:0], serialOutLine};
            repeat (half) @(posedge ref_clk);
            serialClkPin <= 1'b1;
            repeat (half) @(posedge ref_clk);
        end
        serialSyncNPin <= 1'b1;
        repeat (2 * half) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- dv/pmu_status_readback_words_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmu_status_readback_words_tb_top;
    logic ref_clk, nrst, sysCtrlWrite, sysClampEn, sysCmpOutEn, pmuWrite;
    logic pmuChannelOn, pmuForceSwitch, pmuSenseSwitch, pmuClampEn;
    logic pmuCmpOutEn, pmuCompareVolt, pmuClearAlarm, readbackReq;
    logic overTempRaw, serialClkPin, serialSyncNPin, serialOutLine;
    logic serialOutOe, thermAlarmPinOut, thermAlarmPinOe, readbackPending;
    logic [3:0] pmuChanMask, cmpLowRaw, cmpHighRaw;
    logic [1:0] readbackChan;
    prsw_pkg::prsw_word_type readbackKind;
    int fail_count, n_compared;
    localparam prsw_pkg::prsw_word_type pmuKind = prsw_pkg::PRSW_PMU_WORD;
    localparam prsw_pkg::prsw_word_type cmpKind = prsw_pkg::PRSW_CMP_WORD;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    prsw_readback #(.NUM_CHAN(4)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .sysCtrlWrite(sysCtrlWrite), .sysClampEn(sysClampEn),
        .sysCmpOutEn(sysCmpOutEn), .pmuWrite(pmuWrite),
        .pmuChanMask(pmuChanMask), .pmuChannelOn(pmuChannelOn),
        .pmuForceSwitch(pmuForceSwitch), .pmuSenseSwitch(pmuSenseSwitch),
        .pmuClampEn(pmuClampEn), .pmuCmpOutEn(pmuCmpOutEn),
        .pmuCompareVolt(pmuCompareVolt), .pmuClearAlarm(pmuClearAlarm),
        .readbackReq(readbackReq), .readbackKind(readbackKind),
        .readbackChan(readbackChan), .overTempRaw(overTempRaw),
        .cmpLowRaw(cmpLowRaw), .cmpHighRaw(cmpHighRaw),
        .serialClkPin(serialClkPin), .serialSyncNPin(serialSyncNPin),
        .serialOutLine(serialOutLine), .serialOutOe(serialOutOe),
        .thermAlarmPinOut(thermAlarmPinOut),
        .thermAlarmPinOe(thermAlarmPinOe), .readbackPending(readbackPending));
    prsw_host_model host (.ref_clk(ref_clk), .serialOutLine(serialOutLine),
        .serialClkPin(serialClkPin), .serialSyncNPin(serialSyncNPin));

    // Word comparison with counting
    task automatic chk(input string what, input logic [23:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Comparator word: type 01, then low/high per channel from bit 21
    function automatic logic [23:0] cmpw(input logic [3:0] lo, hi);
        cmpw = 24'h400000;
        for (int i = 0; i < 4; i++) begin
            cmpw[21 - 2 * i] = lo[i];
            cmpw[20 - 2 * i] = hi[i];
        end
    endfunction

    // System control write to all channels
    task automatic sys_wr(input logic cl, co);
        {sysCtrlWrite, sysClampEn, sysCmpOutEn} <= {1'b1, cl, co};
        @(posedge ref_clk);
        sysCtrlWrite <= 1'b0;
    endtask

    // PMU write; flags are on, force, sense, clamp, cmp out, volt
    task automatic pmu_wr(input logic [3:0] m, input logic [5:0] f,
                          input logic clr);
        {pmuChannelOn, pmuForceSwitch, pmuSenseSwitch, pmuClampEn,
         pmuCmpOutEn, pmuCompareVolt} <= f;
        {pmuWrite, pmuChanMask, pmuClearAlarm} <= {1'b1, m, clr};
        @(posedge ref_clk);
        pmuWrite <= 1'b0;
    endtask

    // Request a word, check it is pending, shift it out and compare
    task automatic rdc(input string n, input prsw_pkg::prsw_word_type k,
                       input logic [1:0] ch, input logic [23:0] e);
        logic [23:0] v;
        {readbackReq, readbackChan} <= {1'b1, ch};
        readbackKind <= k;
        @(posedge ref_clk);
        readbackReq <= 1'b0;
        @(posedge ref_clk);
        #1 chk("pending", 24'h1, {23'h0, readbackPending});
        host.frame(8, v);
        chk(n, e, v);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        {ref_clk, nrst, sysCtrlWrite, sysClampEn, sysCmpOutEn, pmuWrite} = '0;
        {pmuChannelOn, pmuForceSwitch, pmuSenseSwitch, pmuClampEn} = '0;
        {pmuCmpOutEn, pmuCompareVolt, pmuClearAlarm, readbackReq} = '0;
        {overTempRaw, pmuChanMask, cmpLowRaw, cmpHighRaw, readbackChan} = '0;
        readbackKind = prsw_pkg::PRSW_PMU_WORD;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rdc("reset ch0", pmuKind, 2'h0, 24'h0);
        $display("test reset done");
        pmu_wr(4'h2, 6'h2d, 1'b0);
        rdc("ch1 word", pmuKind, 2'h1, 24'h200680);
        rdc("ch0 word", pmuKind, 2'h0, 24'h0);
        $display("test pmu fields done");
        sys_wr(1'b0, 1'b1);
        rdc("ch1 sys", pmuKind, 2'h1, 24'h200580);
        pmu_wr(4'h2, 6'h34, 1'b0);
        rdc("ch1 pmu", pmuKind, 2'h1, 24'h200a00);
        rdc("ch0 sys", pmuKind, 2'h0, 24'h000100);
        $display("test last write done");
        for (int p = 0; p < 2; p++) begin
            cmpLowRaw <= p ? 4'ha : 4'h5;
            cmpHighRaw <= p ? 4'h3 : 4'hc;
            repeat (6) @(posedge ref_clk);
            rdc("cmp word", cmpKind, 2'h0,
                cmpw(p ? 4'ha : 4'h5, p ? 4'h3 : 4'hc));
        end
        $display("test comparator done");
        overTempRaw <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("alarm pin", 24'h1, {23'h0, thermAlarmPinOe});
        rdc("alarm live", pmuKind, 2'h2, 24'h000160);
        pmu_wr(4'h0, 6'h0, 1'b1);
        overTempRaw <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rdc("alarm held", pmuKind, 2'h2, 24'h000140);
        pmu_wr(4'h0, 6'h0, 1'b1);
        rdc("alarm clear", pmuKind, 2'h2, 24'h000100);
        $display("test alarm done");
        finish_test();
    end
endmodule
`default_nettype wire
